//--- quad_counter_pkg.sv
// constants shared by the quadrature counter range and mask logic
package quad_counter_pkg;

   // register byte offsets
   localparam logic [7:0] CTRL_OFFSET   = 8'h00;
   localparam logic [7:0] EXT_OFFSET    = 8'h04;
   localparam logic [7:0] COUNT_OFFSET  = 8'h08;
   localparam logic [7:0] STATUS_OFFSET = 8'h0C;

   // control word field positions (low byte, then upper input select byte)
   localparam int POS_MODE_LSB   = 0;
   localparam int REV_MODE_LSB   = 2;
   localparam int INDEX_ROLE_BIT = 5;
   localparam int INDEX_SEL_LSB  = 14;
   localparam int B_EDGE_LSB     = 12;
   localparam int A_EDGE_LSB     = 10;
   localparam int MASK_SPAN_LSB  = 8;

   // extension register field positions
   localparam int RANGE_MODE_BIT = 0;
   localparam int OOR_FLAG_BIT   = 1;
   localparam int OOR_IE_BIT     = 2;

   // reset values
   localparam logic [7:0] CTRL_LOW_RESET   = 8'h00;
   localparam logic [7:0] CTRL_UPPER_RESET = 8'h00;
   localparam logic [2:0] EXT_RESET        = 3'h0;

   // two-bit select codes shared by edge, level and mask fields
   localparam logic [1:0] SEL_NONE = 2'h0;
   localparam logic [1:0] SEL_FALL = 2'h1;
   localparam logic [1:0] SEL_RISE = 2'h2;
   localparam logic [1:0] SEL_BOTH = 2'h3;

   // position and revolution mode codes
   localparam logic [1:0] POSITION_DISABLED    = 2'h0;
   localparam logic [1:0] POSITION_UP_DOWN     = 2'h1;
   localparam logic [1:0] POSITION_PHASE_DIFF  = 2'h2;
   localparam logic [1:0] POSITION_DIRECTIONAL = 2'h3;
   localparam logic [1:0] REVOLUTION_DISABLED   = 2'h0;
   localparam logic [1:0] REVOLUTION_INDEX_ONLY = 2'h1;
   localparam logic [1:0] REVOLUTION_WRAP_ONLY  = 2'h2;
   localparam logic [1:0] REVOLUTION_BOTH       = 2'h3;

   // mask spans in position changes
   localparam logic [3:0] MASK_SPAN_TWO   = 4'h2;
   localparam logic [3:0] MASK_SPAN_FOUR  = 4'h4;
   localparam logic [3:0] MASK_SPAN_EIGHT = 4'h8;

   // out-of-range boundaries
   localparam logic [15:0] FULL_DOWN_FROM = 16'h0001;
   localparam logic [15:0] FULL_TOP       = 16'hFFFF;
   localparam logic [15:0] HALF_DOWN_FROM = 16'h8001;
   localparam logic [15:0] HALF_UP_FROM   = 16'h7FFE;

endpackage : quad_counter_pkg

//--- encoder_pin_edge.sv
// input synchroniser and selectable edge detector for one encoder pin
`timescale 1ns/1ns
module encoder_pin_edge (
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       pin,
   input  wire logic [1:0] edge_sel,
   output logic            level,
   output logic            edge_hit
);

   logic meta_q;
   logic sync_q;
   logic prev_q;
   logic rise;
   logic fall;

   // two-stage synchroniser, then one more stage for edge history
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         meta_q <= pin;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // edges come from successive settled samples only
   assign rise  = sync_q & ~prev_q;
   assign fall  = ~sync_q & prev_q;
   assign level = sync_q;
   assign edge_hit = (edge_sel[1] & rise) | (edge_sel[0] & fall);

endmodule : encoder_pin_edge

//--- quad_range_mask.sv
// position and revolution counting with reset mask and out-of-range flag
//
// Function
// - index clear edge: none, fall, rise, both
// - index gate level: low, high, else off
// - phase B edge select: off/fall/rise/both
// - phase A edge select: off/fall/rise/both
// - mask ignores resets, revolution counts after wrap/index
// - mask ends on reversal, re-arms on event
// - mask only in revolution modes 00, 11
// - mode-changing write releases active mask
// - unknown direction: index resets, no revolution count
// - extension upper bits written zero, read zero
// - enabled out-of-range flag raises interrupt
// - full range flags 0001->0000, FFFF stuck
// - half range flags 8001->8000, 7FFE->7FFF
// - write zero clears flag, one keeps
// - flag reads one during read-modify-write
// - range bit picks full or half range
// - index role: edge clear or level gate
// - revolution source: off, index, wrap, both
// - position modes: off, up-down, phase, directional
`timescale 1ns/1ns
module quad_range_mask #(
   parameter int          ADDR_W  = 8,
   parameter logic [15:0] MAX_POS = 16'hFFFF
) (
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              rmw_access,
   input  wire logic              phase_a_input,
   input  wire logic              phase_b_input,
   input  wire logic              index_input,
   output logic      [15:0]       position_count,
   output logic      [15:0]       revolution_count,
   output logic                   last_direction_bit,
   output logic                   overflow_event,
   output logic                   underflow_event,
   output logic                   index_event,
   output logic                   out_of_range_irq
);

   ////////////////////////////////////////////////////////////////////////
   logic [1:0]  pos_mode_q;
   logic [1:0]  rev_mode_q;
   logic        index_role_q;
   logic [7:0]  upper_q;
   logic        range_mode_q;
   logic        oor_flag_q;
   logic        oor_ie_q;
   logic [15:0] pos_q;
   logic [15:0] rev_q;
   logic        dir_q;
   logic        dir_valid_q;
   logic [3:0]  mask_cnt_q;
   logic [31:0] prdata_q;
   logic        pready_q;
   logic        pslverr_q;
   logic        irq_q;
   logic        ovf_q;
   logic        udf_q;
   logic        idx_q;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers; index edge uses the same select field as the gate
   logic [2:0] pin_vec;
   logic [5:0] sel_vec;
   logic [2:0] lvl_vec;
   logic [2:0] hit_vec;
   logic [1:0] index_sel;
   logic [1:0] mask_span;

   assign index_sel = upper_q[quad_counter_pkg::INDEX_SEL_LSB-8 +: 2];
   assign mask_span = upper_q[quad_counter_pkg::MASK_SPAN_LSB-8 +: 2];
   assign pin_vec = {index_input, phase_b_input, phase_a_input};
   assign sel_vec = {index_sel,
                     upper_q[quad_counter_pkg::B_EDGE_LSB-8 +: 2],
                     upper_q[quad_counter_pkg::A_EDGE_LSB-8 +: 2]};

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_pin
         // synchronised sampling ahead of the edge selects
         encoder_pin_edge u_edge (
            .clk      (clk),
            .rst_b    (rst_b),
            .pin      (pin_vec[gi]),
            .edge_sel (sel_vec[2*gi +: 2]),
            .level    (lvl_vec[gi]),
            .edge_hit (hit_vec[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // position step decode per mode
   logic a_hit;
   logic b_hit;
   logic a_lvl;
   logic b_lvl;
   logic gate_open;
   logic pos_run;
   logic step_up;
   logic step_dn;
   logic diff_up;

   assign a_hit = hit_vec[0];
   assign b_hit = hit_vec[1];
   assign a_lvl = lvl_vec[0];
   assign b_lvl = lvl_vec[1];
   // gate open only on a defined level; 00 and 11 keep counting stopped
   assign gate_open = (index_sel == quad_counter_pkg::SEL_FALL & ~lvl_vec[2]) |
                      (index_sel == quad_counter_pkg::SEL_RISE &  lvl_vec[2]);
   assign pos_run = (pos_mode_q != quad_counter_pkg::POSITION_DISABLED) &
                    (~index_role_q | gate_open);
   assign diff_up = (a_hit & (a_lvl ^ b_lvl)) | (b_hit & ~(a_lvl ^ b_lvl));

   // counting methods; coincident a and b edges cancel out except in directional mode
   assign step_up = pos_run & (
      (pos_mode_q == quad_counter_pkg::POSITION_UP_DOWN     & a_hit & ~b_hit) |
      (pos_mode_q == quad_counter_pkg::POSITION_PHASE_DIFF  & (a_hit ^ b_hit) & diff_up) |
      (pos_mode_q == quad_counter_pkg::POSITION_DIRECTIONAL & b_hit & a_lvl));
   assign step_dn = pos_run & (
      (pos_mode_q == quad_counter_pkg::POSITION_UP_DOWN     & b_hit & ~a_hit) |
      (pos_mode_q == quad_counter_pkg::POSITION_PHASE_DIFF  & (a_hit ^ b_hit) & ~diff_up) |
      (pos_mode_q == quad_counter_pkg::POSITION_DIRECTIONAL & b_hit & ~a_lvl));

   ////////////////////////////////////////////////////////////////////////
   // events, mask and revolution source
   logic pos_chg;
   logic ovf;
   logic udf;
   logic idx_act;
   logic reversal;
   logic mask_ok;
   logic mask_active;
   logic arm;
   logic mode_wr_chg;
   logic pos_reset;
   logic rev_src;
   logic rev_go;
   logic rev_up;
   logic [3:0] span_cnt;

   assign pos_chg  = step_up | step_dn;
   assign ovf      = step_up & (pos_q == MAX_POS);
   assign udf      = step_dn & (pos_q == 16'h0000);
   assign idx_act  = ~index_role_q & hit_vec[2] &
                     (pos_mode_q != quad_counter_pkg::POSITION_DISABLED);
   assign reversal = pos_chg & dir_valid_q & (step_up != dir_q);
   assign mask_ok  = (rev_mode_q == quad_counter_pkg::REVOLUTION_DISABLED |
                      rev_mode_q == quad_counter_pkg::REVOLUTION_BOTH) &
                     (mask_span != quad_counter_pkg::SEL_NONE);
   assign mask_active = mask_cnt_q != 4'h0;
   assign arm = mask_ok & (ovf | udf | idx_act);
   assign span_cnt = (mask_span == quad_counter_pkg::SEL_FALL) ? quad_counter_pkg::MASK_SPAN_TWO :
                     (mask_span == quad_counter_pkg::SEL_RISE) ? quad_counter_pkg::MASK_SPAN_FOUR :
                                                                quad_counter_pkg::MASK_SPAN_EIGHT;
   // index clears the count in every revolution mode but wrap-only
   assign pos_reset = idx_act & ~mask_active &
                      (rev_mode_q != quad_counter_pkg::REVOLUTION_WRAP_ONLY);
   assign rev_src = (idx_act & rev_mode_q[0]) | ((ovf | udf) & rev_mode_q[1]);
   // unknown direction blocks index-driven counting
   assign rev_go = rev_src & ~mask_active & (dir_valid_q | ovf | udf);
   assign rev_up = (ovf | udf) ? ovf : dir_q;

   ////////////////////////////////////////////////////////////////////////
   // out-of-range detection
   logic oor_set;
   logic full_hit;
   logic half_hit;

   assign full_hit = (~rev_up & rev_q == quad_counter_pkg::FULL_DOWN_FROM) |
                     ( rev_up & rev_q == quad_counter_pkg::FULL_TOP);
   assign half_hit = (~rev_up & rev_q == quad_counter_pkg::HALF_DOWN_FROM) |
                     ( rev_up & rev_q == quad_counter_pkg::HALF_UP_FROM);
   assign oor_set  = rev_go & (range_mode_q ? half_hit : full_hit);

   ////////////////////////////////////////////////////////////////////////
   // apb decode: setup cycle loads answer, access cycle presents it
   logic setup;
   logic access;
   logic wr_ctrl;
   logic wr_ext;
   logic hit_ctrl;
   logic hit_ext;
   logic hit_cnt;
   logic hit_stat;
   logic [31:0] rd_mux;
   logic        oor_flag_d;

   assign setup    = psel & ~penable;
   assign access   = psel & penable & pready_q;
   assign hit_ctrl = paddr == ADDR_W'(quad_counter_pkg::CTRL_OFFSET);
   assign hit_ext  = paddr == ADDR_W'(quad_counter_pkg::EXT_OFFSET);
   assign hit_cnt  = paddr == ADDR_W'(quad_counter_pkg::COUNT_OFFSET);
   assign hit_stat = paddr == ADDR_W'(quad_counter_pkg::STATUS_OFFSET);
   assign wr_ctrl  = access & pwrite & hit_ctrl;
   assign wr_ext   = access & pwrite & hit_ext;
   assign mode_wr_chg = wr_ctrl &
      ((pwdata[quad_counter_pkg::POS_MODE_LSB +: 2] != pos_mode_q) |
       (pwdata[quad_counter_pkg::REV_MODE_LSB +: 2] != rev_mode_q));
   assign rd_mux = hit_ctrl ? {16'h0000, upper_q, 2'b00, index_role_q, 1'b0,
                               rev_mode_q, pos_mode_q} :
                   hit_ext  ? {29'h00000000, oor_ie_q, oor_flag_q | rmw_access,
                               range_mode_q} :
                   hit_cnt  ? {rev_q, pos_q} :
                   hit_stat ? {30'h00000000, mask_active, dir_q} : 32'h00000000;
   // set wins over a clearing write landing in the same cycle
   assign oor_flag_d = oor_set |
      (oor_flag_q & ~(wr_ext & ~pwdata[quad_counter_pkg::OOR_FLAG_BIT]));

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         prdata_q  <= 32'h00000000;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q  <= setup;
         pslverr_q <= setup & ~(hit_ctrl | hit_ext | hit_cnt | hit_stat);
         prdata_q  <= (setup & ~pwrite) ? rd_mux : 32'h00000000;
      end
   end

   // software-owned control fields, all cleared at reset
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pos_mode_q   <= quad_counter_pkg::CTRL_LOW_RESET[1:0];
         rev_mode_q   <= quad_counter_pkg::CTRL_LOW_RESET[3:2];
         index_role_q <= quad_counter_pkg::CTRL_LOW_RESET[5];
         upper_q      <= quad_counter_pkg::CTRL_UPPER_RESET;
         range_mode_q <= quad_counter_pkg::EXT_RESET[0];
         oor_ie_q     <= quad_counter_pkg::EXT_RESET[2];
         oor_flag_q   <= quad_counter_pkg::EXT_RESET[1];
      end else begin
         oor_flag_q <= oor_flag_d;
         if (wr_ctrl) begin
            pos_mode_q   <= pwdata[quad_counter_pkg::POS_MODE_LSB +: 2];
            rev_mode_q   <= pwdata[quad_counter_pkg::REV_MODE_LSB +: 2];
            index_role_q <= pwdata[quad_counter_pkg::INDEX_ROLE_BIT];
            upper_q      <= pwdata[15:8];
         end
         if (wr_ext) begin
            range_mode_q <= pwdata[quad_counter_pkg::RANGE_MODE_BIT];
            oor_ie_q     <= pwdata[quad_counter_pkg::OOR_IE_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // counters, direction and mask span
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pos_q       <= 16'h0000;
         rev_q       <= 16'h0000;
         dir_q       <= 1'b0;
         dir_valid_q <= 1'b0;
         mask_cnt_q  <= 4'h0;
      end else begin
         if (pos_reset | ovf)                                  pos_q <= 16'h0000;
         else if (udf)                                         pos_q <= MAX_POS;
         else if (step_up)                                     pos_q <= pos_q + 16'h0001;
         else if (step_dn)                                     pos_q <= pos_q - 16'h0001;
         // full range holds at the top instead of wrapping
         if (rev_go & rev_up & ~(~range_mode_q & rev_q == quad_counter_pkg::FULL_TOP))
            rev_q <= rev_q + 16'h0001;
         else if (rev_go & ~rev_up)
            rev_q <= rev_q - 16'h0001;
         // direction is forgotten whenever the position mode is disabled
         if (pos_mode_q == quad_counter_pkg::POSITION_DISABLED) begin
            dir_valid_q <= 1'b0;
         end else if (pos_chg) begin
            dir_valid_q <= 1'b1;
            dir_q       <= step_up;
         end
         if (arm)                                      mask_cnt_q <= span_cnt;
         else if (mode_wr_chg | reversal | ~mask_ok)   mask_cnt_q <= 4'h0;
         else if (pos_chg & mask_active)               mask_cnt_q <= mask_cnt_q - 4'h1;
      end
   end

   // registered event pulses and interrupt request
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_q <= 1'b0;
         ovf_q <= 1'b0;
         udf_q <= 1'b0;
         idx_q <= 1'b0;
      end else begin
         irq_q <= oor_ie_q & oor_flag_q;
         ovf_q <= ovf;
         udf_q <= udf;
         idx_q <= pos_reset;
      end
   end

   assign prdata             = prdata_q;
   assign pready             = pready_q;
   assign pslverr            = pslverr_q;
   assign position_count     = pos_q;
   assign revolution_count   = rev_q;
   assign last_direction_bit = dir_q;
   assign overflow_event     = ovf_q;
   assign underflow_event    = udf_q;
   assign index_event        = idx_q;
   assign out_of_range_irq   = irq_q;

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   property p_flag_keep;
      (wr_ext && pwdata[1] && oor_flag_q) |=> oor_flag_q;
   endproperty
   a_flag_keep: assert property (p_flag_keep) else $error("flag lost on write one");

   property p_flag_clear;
      (wr_ext && !pwdata[1] && !oor_set) |=> !oor_flag_q;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

   property p_full_down;
      (rev_go && !rev_up && !range_mode_q && rev_q == 16'h0001) |=>
         (oor_flag_q && rev_q == 16'h0000);
   endproperty
   a_full_down: assert property (p_full_down) else $error("full range underrun missed");

   property p_half_up;
      (rev_go && rev_up && range_mode_q && rev_q == 16'h7FFE) |=>
         (oor_flag_q && rev_q == 16'h7FFF);
   endproperty
   a_half_up: assert property (p_half_up) else $error("half range overrun missed");

   property p_irq;
      (oor_ie_q && oor_flag_q) |=> out_of_range_irq;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt not raised");

   property p_irq_off;
      !oor_ie_q |=> !out_of_range_irq;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("interrupt while disabled");

   property p_reserved;
      (setup && !pwrite && hit_ext) |=> (prdata[31:3] == 29'h00000000);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

   property p_mask_hold;
      (mask_active && rev_src) |=> $stable(rev_q);
   endproperty
   a_mask_hold: assert property (p_mask_hold) else $error("revolution counted under mask");

   property p_mask_load;
      (arm && mask_span == 2'h1) |=> (mask_cnt_q == 4'h2);
   endproperty
   a_mask_load: assert property (p_mask_load) else $error("mask span wrong");

   property p_mask_release;
      (mode_wr_chg || reversal) && !arm |=> !mask_active;
   endproperty
   a_mask_release: assert property (p_mask_release) else $error("mask not released");

   property p_no_dir;
      (idx_act && !dir_valid_q && !ovf && !udf) |=> $stable(rev_q);
   endproperty
   a_no_dir: assert property (p_no_dir) else $error("counted with unknown direction");

   c_oor:  cover property (oor_set);
   c_arm:  cover property (arm ##[1:20] !mask_active);
   c_irq:  cover property (out_of_range_irq);

endmodule : quad_range_mask

//--- encoder_model.sv
// incremental encoder model driving the phase and index pins
`timescale 1ns/1ns
module encoder_model (
   input  wire logic clk,
   output logic      pin_a,
   output logic      pin_b,
   output logic      pin_z
);
   // pins idle low until the first pulse
   initial begin
      pin_a = 1'b0;
      pin_b = 1'b0;
      pin_z = 1'b0;
   end
   //////////////////////////////////////////////////////////////////////////
   // one full pulse; hold sets a quick or a slow encoder, each level lasts hold+1 clk
   task automatic pulse(input int which, input int hold);
      for (int i = 0; i < 2; i++) begin
         @(posedge clk);
         case (which)
            0: pin_a <= ~pin_a;
            1: pin_b <= ~pin_b;
            default: pin_z <= ~pin_z;
         endcase
         repeat (hold) @(posedge clk);
      end
   endtask : pulse
endmodule : encoder_model

//--- quad_range_mask_tb.sv
// self-checking bench for the quadrature range and mask block
`timescale 1ns/1ns
module quad_range_mask_tb;
   localparam logic [15:0] MAXP = 16'h0007;
   logic        clk, rst_b, psel, penable, pwrite, rmw_access;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rnd;
   logic        pready, pslverr, pa, pb, pz, irq;
   logic [15:0] pos_o, rev_o;
   logic        dir_o, ovf_o, udf_o, idx_o;
   logic [32:0] expq[$];
   int          miscompares, n_checks, n, p, ep;
   int          n_ovf, n_udf, n_idx, so, su, si;

   quad_range_mask #(.ADDR_W(8), .MAX_POS(MAXP)) uut (
      .clk(clk), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rmw_access(rmw_access), .phase_a_input(pa),
      .phase_b_input(pb), .index_input(pz), .position_count(pos_o),
      .revolution_count(rev_o), .last_direction_bit(dir_o), .overflow_event(ovf_o),
      .underflow_event(udf_o), .index_event(idx_o), .out_of_range_irq(irq));
   encoder_model enc (.clk(clk), .pin_a(pa), .pin_b(pb), .pin_z(pz));

   //////////////////////////////////////////////////////////////////////////
   // 50 MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic check(input logic [32:0] seen, input logic [32:0] want);
      n_checks++;
      if (seen !== want) begin
         miscompares++;
         $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, want);
      end
   endtask : check

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop

   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      psel   <= 1'b1;
      paddr  <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 10);
      psel    <= 1'b0;
      penable <= 1'b0;
      if (k >= 10 && pready !== 1'b1) begin
         miscompares++;
         report_and_stop();
      end
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [32:0] want);
      expq.push_back(want);
      apb(a, 1'b0, 32'h0);
   endtask : rd

   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs

   //////////////////////////////////////////////////////////////////////////
   // read monitor: oldest note against each completed read, slverr on top
   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0)
         check({pslverr, prdata}, expq.pop_front());
   end

   // event pulse tally; each pulse stands one cycle so counts once
   always @(posedge clk) begin
      n_ovf <= n_ovf + int'(ovf_o);
      n_udf <= n_udf + int'(udf_o);
      n_idx <= n_idx + int'(idx_o);
   end

   //////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 8'h00; pwdata = 32'h0; rmw_access = 1'b0;
      miscompares = 0; n_checks = 0; rnd = 32'h84d914ef; ep = 0;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      rd(8'h00, 33'h0);
      rd(8'h04, 33'h0);
      rd(8'h10, {1'b1, 32'h0});
      apb(8'h04, 1'b1, 32'h7);
      rd(8'h04, 33'h5);
      apb(8'h04, 1'b1, 32'h0);
      $display("test registers done");
      // every edge code on A then B, random pulse counts; wraps at MAXP
      for (p = 0; p < 2; p++) begin
         for (int s = 0; s < 4; s++) begin
            apb(8'h00, 1'b1, 32'h1 | (s << (10 + 2 * p)));
            rnd = xs(rnd);
            n = 1 + int'(rnd % 3);
            repeat (n) enc.pulse(p, 3 + 4 * p);
            n = n * (s % 2 + s / 2);
            ep = p ? (ep + 16 - n) % 8 : (ep + n) % 8;
            rd(8'h08, {17'h0, 16'(ep)});
         end
      end
      $display("test edge selects done");
      // wrap-only revolutions: underflow to FFFF, then count-up sticks and flags
      so = n_ovf;
      su = n_udf;
      apb(8'h00, 1'b1, 32'h2809);
      repeat (ep + 1) enc.pulse(1, 4);
      enc.pulse(0, 4);
      rd(8'h08, {1'b0, 16'hFFFF, 16'h0});
      rd(8'h04, 33'h2);
      check(33'(n_ovf - so), 33'h1);
      check(33'(n_udf - su), 33'h1);
      check({32'h0, irq}, 33'h0);
      apb(8'h04, 1'b1, 32'h6);
      repeat (3) @(posedge clk);
      check({32'h0, irq}, 33'h1);
      apb(8'h04, 1'b1, 32'h4);
      rd(8'h04, 33'h4);
      rmw_access <= 1'b1;
      rd(8'h04, 33'h6);
      rmw_access <= 1'b0;
      check({32'h0, irq}, 33'h0);
      $display("test out of range done");
      // leave disabled mode, index first, then mask and its release
      si = n_idx;
      repeat (2) enc.pulse(0, 4);
      apb(8'h00, 1'b1, 32'h0);
      apb(8'h00, 1'b1, 32'h890D);
      enc.pulse(2, 5);
      rd(8'h08, {1'b0, 16'hFFFF, 16'h0});
      enc.pulse(0, 4);
      enc.pulse(2, 5);
      rd(8'h08, {1'b0, 16'hFFFF, 16'h1});
      rd(8'h0C, 33'h3);
      apb(8'h00, 1'b1, 32'h890F);
      rd(8'h0C, 33'h1);
      // re-arm on index, one step up, then a step down must drop the mask
      apb(8'h00, 1'b1, 32'hA90D);
      enc.pulse(2, 5);
      enc.pulse(0, 4);
      enc.pulse(1, 4);
      rd(8'h0C, 33'h0);
      apb(8'h00, 1'b1, 32'h8905);
      enc.pulse(2, 5);
      rd(8'h08, {1'b0, 16'hFFFE, 16'h0});
      rd(8'h0C, 33'h0);
      check(33'(n_idx - si), 33'h3);
      $display("test reset mask done");
      // gate role: low-level gate counts, high-level gate stops while index stays low
      apb(8'h00, 1'b1, 32'h4821);
      enc.pulse(0, 4);
      apb(8'h00, 1'b1, 32'h8821);
      enc.pulse(0, 4);
      rd(8'h08, {1'b0, 16'hFFFE, 16'h1});
      check({1'b0, rev_o, pos_o}, {1'b0, 16'hFFFE, 16'h1});
      check({32'h0, dir_o}, 33'h1);
      $display("test gate done");
      repeat (3) @(posedge clk);
      report_and_stop();
   end
endmodule : quad_range_mask_tb
